// file: logic/osr_otp_engine.sv
// Programmable configuration memory engine: timed write, read and lock commands
`timescale 1ns/1ns
module osr_otp_engine
	import osr_pkg::*;
#(
	parameter int DEPTH       = 64,
	parameter int PROG_CYCLES = OTP_PROG_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	osr_otp_if.eng   otp
);
	localparam int CNT_W = $clog2(PROG_CYCLES + 1);

	osr_eng_state_t state;
	logic [CNT_W-1:0] count;
	osr_cmd_t         cur_cmd;
	logic [7:0]       cur_addr;
	logic [7:0]       cur_data;
	logic [7:0]       mem [DEPTH];
	logic             integrity_fail;
	logic             in_range;
	logic [7:0]       merged;

	assign in_range = 32'(cur_addr) < DEPTH;
	// Fuses only ever go from 0 to 1, so a write can only add bits
	assign merged   = in_range ? (mem[cur_addr[$clog2(DEPTH)-1:0]] | cur_data) : 8'h00;
	assign otp.busy = state != ST_IDLE;

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state    <= ST_IDLE;
			count    <= '0;
			cur_cmd  <= CMD_NONE;
			cur_addr <= 8'h00;
			cur_data <= 8'h00;
			otp.done <= 1'b0;
		end else begin
			otp.done <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (otp.start) begin
						state    <= ST_PROG;
						count    <= CNT_W'(PROG_CYCLES - 1);
						cur_cmd  <= otp.cmd;
						cur_addr <= otp.addr;
						cur_data <= otp.wdata;
					end
				end
				ST_PROG: begin
					if (count == '0) begin
						state    <= ST_DONE;
						otp.done <= 1'b1;
					end else begin
						count <= count - 1'b1;
					end
				end
				ST_DONE: begin
					state <= ST_IDLE;
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	assign otp.done_cmd = cur_cmd;

	// ----------------------------------------------------------------
	// Results, held until the next command of the same kind
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			otp.wr_ok      <= 1'b0;
			otp.wr_denied  <= 1'b0;
			otp.lock_ok    <= 1'b0;
			otp.crc_ok     <= 1'b0;
			otp.used       <= 1'b0;
			otp.locked     <= 1'b0;
			otp.checked    <= 1'b0;
			otp.rdata      <= 8'h00;
			integrity_fail <= 1'b0;
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= 8'h00;
			end
		end else if (state == ST_PROG && count == '0) begin
			case (cur_cmd)
				CMD_WR: begin
					if (!otp.key_on || otp.locked) begin
						otp.wr_denied <= 1'b1;
						otp.wr_ok     <= 1'b0;
					end else begin
						otp.wr_denied <= 1'b0;
						otp.wr_ok     <= in_range && merged == cur_data;
						integrity_fail <= integrity_fail | !(in_range && merged == cur_data);
						otp.used      <= 1'b1;
						if (in_range) begin
							mem[cur_addr[$clog2(DEPTH)-1:0]] <= merged;
						end
					end
				end
				CMD_RD: begin
					otp.rdata <= in_range ? mem[cur_addr[$clog2(DEPTH)-1:0]] : 8'h00;
				end
				CMD_LOCK: begin
					otp.lock_ok <= otp.key_on;
					otp.checked <= 1'b1;
					otp.crc_ok  <= !integrity_fail;
					if (otp.key_on) begin
						otp.locked <= 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
	end

endmodule

// file: logic/osr_otp_if.sv
// Link between the register front end and the programmable memory engine
`timescale 1ns/1ns
interface osr_otp_if;
	import osr_pkg::*;
	logic     start;
	osr_cmd_t cmd;
	logic     [7:0] addr;
	logic     [7:0] wdata;
	logic     key_on;
	logic     busy;
	logic     done;
	osr_cmd_t done_cmd;
	logic     [7:0] rdata;
	logic     wr_ok;
	logic     wr_denied;
	logic     lock_ok;
	logic     crc_ok;
	logic     used;
	logic     locked;
	logic     checked;

	modport ctrl (output start, cmd, addr, wdata, key_on,
		input busy, done, done_cmd, rdata, wr_ok, wr_denied, lock_ok, crc_ok, used, locked,
		checked);
	modport eng (input start, cmd, addr, wdata, key_on,
		output busy, done, done_cmd, rdata, wr_ok, wr_denied, lock_ok, crc_ok, used, locked,
		checked);
endinterface

// file: logic/osr_otp_regs.sv
// APB register bank: configuration memory status, laser test mode, revision and resolution
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ns

// Contract
// - Result status at 0x50 read-only; bit2 lock success, bit3 check success.
// - Result bit0 is last write success, bit1 is write refused.
// - Run status at 0x51 is read-only.
// - Run status bit0 is one when ready, zero while busy.
// - Run status bits 4, 5, 6 show used, locked and checked.
// - Laser mode bits 2 and 0: 11 continuous, 00 pulsed; reset zero.
// - Continuous only when companion bits 2 and 0 are the complement.
// - Register 0x7E returns the inverted revision identifier.
// - Enable key all zero means built-in settings are used.
// - Resolution code bits 4:0 at 0xBC, reset 0x0A, applies after power-up.
// - That code is the first on-the-fly resolution setting.
// - Command bits at 0x4F clear themselves when the command completes.
module osr_otp_regs
	import osr_pkg::*;
#(
	parameter logic [7:0] REVISION_ID = 8'h05, // Arbitrary value
	parameter int         OTP_DEPTH   = 64,
	parameter int         PROG_CYCLES = OTP_PROG_CYCLES
) (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [osr_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]           pwdata,
	input  wire logic [3:0]            pstrb,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	output logic                       irq,
	output logic                       continuous_laser,
	output logic                       use_otp_config,
	output logic [osr_pkg::RES_CODE_W-1:0] base_resolution_code
);
	import osr_pkg::*;

	osr_otp_if otp ();

	logic [7:0]       otp_addr;
	logic [7:0]       otp_data;
	logic [2:0]       otp_ctrl;
	logic [7:0]       laser_drive_mode;
	logic [7:0]       laser_drive_complement;
	logic [7:0]       otp_enable_key;
	logic [7:0]       base_resolution;
	logic [IRQ_W-1:0] irq_status;
	logic [IRQ_W-1:0] irq_mask;
	logic             start_q;
	osr_cmd_t         cmd_q;

	logic             access;
	logic             complete;
	logic             wr_en;
	logic             dev_ready;
	logic [7:0]       result_status;
	logic [7:0]       run_status;
	logic [7:0]       next_rdata;
	logic             next_err;
	logic             next_laser;
	logic [IRQ_W-1:0] irq_event;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
		return a == reg_addr(idx);
	endfunction

	function automatic logic wr_hit(input logic en, input logic [ADDR_W-1:0] a,
			input logic [7:0] idx);
		return en && hit(a, idx);
	endfunction

	// ----------------------------------------------------------------
	// APB handshake
	// ----------------------------------------------------------------
	// One wait state: pready rises in the second access cycle, registered
	assign access   = psel && penable && !pready;
	assign complete = psel && penable && pready;
	// Only the low byte carries register data
	assign wr_en    = complete && pwrite && pstrb[0] && !pslverr;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else if (access) begin
			pready  <= 1'b1;
			pslverr <= next_err;
			prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, next_rdata};
		end else begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Status views
	// ----------------------------------------------------------------
	// Ready drops on the accepting edge itself, before the engine turns busy,
	// so a poll in the very next cycle already reads busy
	assign dev_ready = !start_q && (otp_ctrl == 3'h0) && !otp.busy;

	always_comb begin
		result_status                = 8'h00;
		result_status[RES_WR_OK]     = otp.wr_ok;
		result_status[RES_WR_DENIED] = otp.wr_denied;
		result_status[RES_LOCK_OK]   = otp.lock_ok;
		result_status[RES_CRC_OK]    = otp.crc_ok;
		run_status                   = 8'h00;
		run_status[RUN_READY]        = dev_ready;
		run_status[RUN_USED]         = otp.used;
		run_status[RUN_LOCKED]       = otp.locked;
		run_status[RUN_CHECKED]      = otp.checked;
	end

	// ----------------------------------------------------------------
	// Read decode
	// ----------------------------------------------------------------
	// Unmapped indices answer with an error and have no side effect
	always_comb begin
		next_rdata = 8'h00;
		next_err   = 1'b0;
		if (hit(paddr, IDX_OTP_ADDR)) begin
			next_rdata = otp_addr;
		end else if (hit(paddr, IDX_OTP_DATA)) begin
			next_rdata = otp_data;
		end else if (hit(paddr, IDX_OTP_CTRL)) begin
			next_rdata = {5'h00, otp_ctrl};
		end else if (hit(paddr, IDX_RESULT)) begin
			next_rdata = result_status;
		end else if (hit(paddr, IDX_RUN)) begin
			next_rdata = run_status;
		end else if (hit(paddr, IDX_LSR_MODE)) begin
			next_rdata = laser_drive_mode;
		end else if (hit(paddr, IDX_LSR_COMP)) begin
			next_rdata = laser_drive_complement;
		end else if (hit(paddr, IDX_INV_REV)) begin
			next_rdata = ~REVISION_ID;
		end else if (hit(paddr, IDX_KEY)) begin
			next_rdata = otp_enable_key;
		end else if (hit(paddr, IDX_BASE_RES)) begin
			next_rdata = base_resolution;
		end else if (hit(paddr, IDX_IRQ_STAT)) begin
			next_rdata = {{(8 - IRQ_W){1'b0}}, irq_status};
		end else if (hit(paddr, IDX_IRQ_MASK)) begin
			next_rdata = {{(8 - IRQ_W){1'b0}}, irq_mask};
		end else begin
			next_err = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Memory command registers
	// ----------------------------------------------------------------
	// Address and data are frozen while a command runs so the engine
	// never sees them change mid-program.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			otp_addr <= 8'h00;
		end else if (wr_hit(wr_en, paddr, IDX_OTP_ADDR) && dev_ready) begin
			otp_addr <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			otp_data <= 8'h00;
		end else if (otp.done && otp.done_cmd == CMD_RD) begin
			otp_data <= otp.rdata;
		end else if (wr_hit(wr_en, paddr, IDX_OTP_DATA) && dev_ready) begin
			otp_data <= pwdata[7:0];
		end
	end

	// One command at a time; write beats read beats lock if several are set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			otp_ctrl <= 3'h0;
			start_q  <= 1'b0;
			cmd_q    <= CMD_NONE;
		end else begin
			start_q <= 1'b0;
			if (otp.done) begin
				otp_ctrl <= 3'h0;
			end else if (wr_hit(wr_en, paddr, IDX_OTP_CTRL) && dev_ready) begin
				if (pwdata[CTRL_WR]) begin
					otp_ctrl <= 3'h1 << CTRL_WR;
					cmd_q    <= CMD_WR;
					start_q  <= 1'b1;
				end else if (pwdata[CTRL_RD]) begin
					otp_ctrl <= 3'h1 << CTRL_RD;
					cmd_q    <= CMD_RD;
					start_q  <= 1'b1;
				end else if (pwdata[CTRL_LOCK]) begin
					otp_ctrl <= 3'h1 << CTRL_LOCK;
					cmd_q    <= CMD_LOCK;
					start_q  <= 1'b1;
				end
			end
		end
	end

	assign otp.start  = start_q;
	assign otp.cmd    = cmd_q;
	assign otp.addr   = otp_addr;
	assign otp.wdata  = otp_data;
	// Only the full key arms programming; partial keys do not
	assign otp.key_on = otp_enable_key == KEY_ENABLE;

	osr_otp_engine #(
		.DEPTH       (OTP_DEPTH),
		.PROG_CYCLES (PROG_CYCLES)
	) u_engine (
		.pclk    (pclk),
		.presetn (presetn),
		.otp     (otp.eng)
	);

	// ----------------------------------------------------------------
	// Laser test registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			laser_drive_mode <= LSR_MODE_RESET;
		end else if (wr_hit(wr_en, paddr, IDX_LSR_MODE)) begin
			laser_drive_mode <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			laser_drive_complement <= LSR_COMP_RESET;
		end else if (wr_hit(wr_en, paddr, IDX_LSR_COMP)) begin
			laser_drive_complement <= pwdata[7:0];
		end
	end

	// Mixed mode codes 01 and 10 stay in pulsed operation
	assign next_laser = laser_drive_mode[LSR_HI] && laser_drive_mode[LSR_LO]
		&& laser_drive_complement[LSR_HI] == !laser_drive_mode[LSR_HI]
		&& laser_drive_complement[LSR_LO] == !laser_drive_mode[LSR_LO];

	// Registered, so the laser driver sees the decoded mode pair one cycle after it changes, half-written or not
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			continuous_laser <= 1'b0;
		end else begin
			continuous_laser <= next_laser;
		end
	end

	// ----------------------------------------------------------------
	// Configuration key and resolution
	// ----------------------------------------------------------------
	// All eight bits kept; a partial key still selects the stored resolution
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			otp_enable_key <= KEY_RESET;
		end else if (wr_hit(wr_en, paddr, IDX_KEY)) begin
			otp_enable_key <= pwdata[7:0];
		end
	end

	// Bits 7:5 are not stored and read back as zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			base_resolution <= BASE_RES_RESET;
		end else if (wr_hit(wr_en, paddr, IDX_BASE_RES)) begin
			base_resolution <= {3'h0, pwdata[RES_CODE_W-1:0]};
		end
	end

	// Zero key falls back to the built-in resolution
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			use_otp_config       <= 1'b0;
			base_resolution_code <= BASE_RES_RESET[RES_CODE_W-1:0];
		end else begin
			use_otp_config <= otp_enable_key != 8'h00;
			if (otp_enable_key == 8'h00) begin
				base_resolution_code <= BASE_RES_RESET[RES_CODE_W-1:0];
			end else begin
				base_resolution_code <= base_resolution[RES_CODE_W-1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	// Laser event marks entry to continuous mode only, not staying in it
	always_comb begin
		irq_event             = '0;
		irq_event[IRQ_DONE]   = otp.done;
		irq_event[IRQ_DENIED] = otp.done && otp.done_cmd == CMD_WR && !otp.key_on;
		irq_event[IRQ_LASER]  = next_laser && !continuous_laser;
	end

	// A new event wins over a write-one-to-clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= '0;
		end else if (wr_hit(wr_en, paddr, IDX_IRQ_STAT)) begin
			irq_status <= (irq_status & ~pwdata[IRQ_W-1:0]) | irq_event;
		end else begin
			irq_status <= irq_status | irq_event;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask <= '0;
		end else if (wr_hit(wr_en, paddr, IDX_IRQ_MASK)) begin
			irq_mask <= pwdata[IRQ_W-1:0];
		end
	end

	// Registered output: one cycle of interrupt latency traded for a clean pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status & irq_mask);
		end
	end

endmodule

// file: logic/osr_pkg.sv
// Shared constants and types for the sensor configuration and laser test registers
package osr_pkg;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam int         ADDR_W           = 12;
	localparam logic [7:0] IDX_OTP_ADDR     = 8'h4d;
	localparam logic [7:0] IDX_OTP_DATA     = 8'h4e;
	localparam logic [7:0] IDX_OTP_CTRL     = 8'h4f;
	localparam logic [7:0] IDX_RESULT       = 8'h50;
	localparam logic [7:0] IDX_RUN          = 8'h51;
	localparam logic [7:0] IDX_LSR_MODE     = 8'h75;
	localparam logic [7:0] IDX_LSR_COMP     = 8'h76;
	localparam logic [7:0] IDX_INV_REV      = 8'h7e;
	localparam logic [7:0] IDX_KEY          = 8'hbb;
	localparam logic [7:0] IDX_BASE_RES     = 8'hbc;
	localparam logic [7:0] IDX_IRQ_STAT     = 8'he0;
	localparam logic [7:0] IDX_IRQ_MASK     = 8'he1;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int RES_WR_OK      = 0;
	localparam int RES_WR_DENIED  = 1;
	localparam int RES_LOCK_OK    = 2;
	localparam int RES_CRC_OK     = 3;
	localparam int RUN_READY      = 0;
	localparam int RUN_USED       = 4;
	localparam int RUN_LOCKED     = 5;
	localparam int RUN_CHECKED    = 6;
	localparam int CTRL_WR        = 0;
	localparam int CTRL_RD        = 1;
	localparam int CTRL_LOCK      = 2;
	localparam int LSR_HI         = 2;
	localparam int LSR_LO         = 0;
	localparam int RES_CODE_W     = 5;
	localparam int IRQ_DONE       = 0;
	localparam int IRQ_DENIED     = 1;
	localparam int IRQ_LASER      = 2;
	localparam int IRQ_W          = 3;

	// ----------------------------------------------------------------
	// Reset values and keys
	// ----------------------------------------------------------------
	localparam logic [7:0] LSR_MODE_RESET   = 8'h00;
	localparam logic [7:0] LSR_COMP_RESET   = 8'h0f;
	localparam logic [7:0] KEY_RESET        = 8'h00;
	localparam logic [7:0] KEY_ENABLE       = 8'hff;
	localparam logic [7:0] BASE_RES_RESET   = 8'h0a;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS    = 100;
	localparam int OTP_PROG_TIME_NS = 10000;
	localparam int OTP_PROG_CYCLES  = (OTP_PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		CMD_NONE = 2'h0,
		CMD_WR   = 2'h1,
		CMD_RD   = 2'h2,
		CMD_LOCK = 2'h3
	} osr_cmd_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_PROG = 3'h2,
		ST_DONE = 3'h4
	} osr_eng_state_t;

	function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
		return {2'h0, idx, 2'h0};
	endfunction

endpackage

// file: tb/osr_otp_regs_chk.sv
// Port-level assertions for the configuration status and laser test register bank
`timescale 1ns/1ns
module osr_otp_regs_chk
	import osr_pkg::*;
#(
	parameter logic [7:0] REVISION_ID = 8'h05 // Arbitrary value
) (
	input wire logic                          pclk,
	input wire logic                          presetn,
	input wire logic                          psel,
	input wire logic                          penable,
	input wire logic                          pwrite,
	input wire logic [osr_pkg::ADDR_W-1:0]     paddr,
	input wire logic [31:0]                   pwdata,
	input wire logic [3:0]                    pstrb,
	input wire logic [31:0]                   prdata,
	input wire logic                          pready,
	input wire logic                          pslverr,
	input wire logic                          irq,
	input wire logic                          continuous_laser,
	input wire logic                          use_otp_config,
	input wire logic [osr_pkg::RES_CODE_W-1:0] base_resolution_code
);
	logic wr_done;
	logic rd_done;

	// Read data is only meaningful on a completed, accepted read
	assign wr_done = psel && penable && pready && pwrite;
	assign rd_done = psel && penable && pready && !pwrite && !pslverr;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_one_wait_state: assert property (psel && !penable |=> !pready ##1 pready)
		else $error("transfer did not end after exactly one wait state");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready stood longer than one cycle");
	a_error_with_ready: assert property (pslverr |-> pready && psel && penable)
		else $error("pslverr outside a completing access");
	a_status_mapped: assert property (
		pready && (paddr == 12'h140 || paddr == 12'h144 || paddr == 12'h1f8) |-> !pslverr)
		else $error("status register access reported an error");
	a_result_reserved: assert property (rd_done && paddr == 12'h140 |-> prdata[7:4] == 4'h0)
		else $error("result status reserved bits not zero");
	a_run_reserved: assert property (rd_done && paddr == 12'h144 |->
		prdata[7] == 1'b0 && prdata[3:1] == 3'h0)
		else $error("run status reserved bits not zero");
	a_inverted_revision: assert property (rd_done && paddr == 12'h1f8 |->
		prdata[7:0] == ~REVISION_ID)
		else $error("inverted revision read wrong");
	a_upper_zero: assert property (rd_done |-> prdata[31:8] == 24'h0)
		else $error("read data above bit 7 not zero");
	a_builtin_res: assert property (!use_otp_config |-> base_resolution_code == 5'h0a)
		else $error("built-in resolution not applied while key is zero");
	a_outputs_by_write: assert property (
		$changed({continuous_laser, use_otp_config, base_resolution_code}) |->
		$past(wr_done) || $past(wr_done, 2))
		else $error("control output moved without a register write");
endmodule

bind osr_otp_regs osr_otp_regs_chk #(.REVISION_ID(REVISION_ID)) u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .irq(irq), .continuous_laser(continuous_laser),
	.use_otp_config(use_otp_config), .base_resolution_code(base_resolution_code));

// file: tb/osr_otp_regs_tb.sv
// Self-checking bench for the configuration status and laser test register bank
`timescale 1ns/1ns
module osr_otp_regs_tb;
	import osr_pkg::*;
	localparam logic [7:0] REV = 8'h05; // Arbitrary value
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic        continuous_laser;
	logic        use_otp_config;
	logic [4:0]  base_resolution_code;
	logic [31:0] rdat;
	logic        rerr;
	int          error_cnt;
	int          n_tests;

	osr_otp_regs #(.REVISION_ID(REV), .PROG_CYCLES(4)) uut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .continuous_laser(continuous_laser),
		.use_otp_config(use_otp_config), .base_resolution_code(base_resolution_code));

	always #50 pclk = ~pclk;

	task automatic end_of_test;
		if (error_cnt == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One APB transfer; the request is held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd,
		input logic [3:0] st);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= {2'h0, idx, 2'h0};
		pwdata  <= {24'h0, wd};
		pstrb   <= st;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		chk("wait", 32'd2, n);
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
		apb(1'b1, idx, wd, 4'hf);
	endtask

	task automatic rchk(input string what, input logic [7:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 8'h00, 4'hf);
		chk(what, exp, rdat);
	endtask

	task automatic settle;
		repeat (3) @(posedge pclk);
	endtask

	// Issue a command, see it busy, poll run status until ready, then its bits are clear
	task automatic cmd(input logic [7:0] c);
		wr(IDX_OTP_CTRL, c);
		apb(1'b0, IDX_RUN, 8'h00, 4'hf);
		chk("busy", 32'h0, {31'h0, rdat[0]});
		do begin
			apb(1'b0, IDX_RUN, 8'h00, 4'hf);
		end while (rdat[0] !== 1'b1);
		rchk("ctrl", IDX_OTP_CTRL, 32'h0);
	endtask

	initial begin
		logic [7:0] ro [3];
		logic [7:0] roe [3];
		logic [7:0] d;
		logic [7:0] r;
		ro = '{IDX_RESULT, IDX_RUN, IDX_INV_REV};
		roe = '{8'h00, 8'h01, ~REV};
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		pstrb = 4'h0;
		error_cnt = 0;
		n_tests = 0;
		void'($urandom(32'h9473));
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rchk("mode", IDX_LSR_MODE, 32'h00);
		rchk("comp", IDX_LSR_COMP, 32'h0f);
		rchk("key", IDX_KEY, 32'h00);
		rchk("res", IDX_BASE_RES, 32'h0a);
		chk("res_out", 32'h0a, {27'h0, base_resolution_code});
		// Writes to read-only places must leave them untouched
		foreach (ro[k]) begin
			wr(ro[k], 8'($urandom));
			chk("ro_err", 32'h0, {31'h0, rerr});
			rchk("ro", ro[k], {24'h0, roe[k]});
		end
		apb(1'b0, 8'h10, 8'h00, 4'hf);
		chk("unmapped", 32'h1, {31'h0, rerr});
		apb(1'b1, IDX_LSR_MODE, 8'h05, 4'h0);
		rchk("strb", IDX_LSR_MODE, 32'h00);
		wr(IDX_IRQ_MASK, 8'h04);
		for (int i = 0; i < 16; i++) begin
			wr(IDX_LSR_MODE, {5'h0, i[1], 1'b0, i[0]});
			wr(IDX_LSR_COMP, {5'h0, i[3], 1'b0, i[2]});
			settle();
			chk("laser", {31'h0, i == 3}, {31'h0, continuous_laser});
		end
		chk("irq", 32'h1, {31'h0, irq});
		rchk("irq_stat", IDX_IRQ_STAT, 32'h04);
		wr(IDX_IRQ_MASK, 8'h00);
		settle();
		chk("irq_masked", 32'h0, {31'h0, irq});
		wr(IDX_IRQ_MASK, 8'h04);
		wr(IDX_IRQ_STAT, 8'h04);
		settle();
		chk("irq_clear", 32'h0, {31'h0, irq});
		r = 8'($urandom);
		wr(IDX_BASE_RES, r);
		rchk("res", IDX_BASE_RES, {27'h0, r[4:0]});
		chk("res_out", 32'h0a, {27'h0, base_resolution_code});
		wr(IDX_KEY, 8'($urandom_range(254, 1)));
		settle();
		chk("use_cfg", 32'h1, {31'h0, use_otp_config});
		chk("res_out", {27'h0, r[4:0]}, {27'h0, base_resolution_code});
		wr(IDX_KEY, 8'hff);
		wr(IDX_BASE_RES, r);
		wr(IDX_OTP_ADDR, 8'h05);
		d = 8'($urandom);
		wr(IDX_OTP_DATA, d);
		cmd(8'h01);
		rchk("result", IDX_RESULT, 32'h01);
		rchk("run", IDX_RUN, 32'h11);
		rchk("irq_stat", IDX_IRQ_STAT, 32'h01);
		wr(IDX_OTP_DATA, 8'h00);
		cmd(8'h02);
		rchk("otp_data", IDX_OTP_DATA, {24'h0, d});
		cmd(8'h04);
		rchk("result", IDX_RESULT, 32'h0d);
		rchk("run", IDX_RUN, 32'h71);
		wr(IDX_OTP_DATA, 8'hff);
		cmd(8'h01);
		rchk("result", IDX_RESULT, 32'h0e);
		wr(IDX_KEY, 8'h5a);
		cmd(8'h01);
		rchk("result", IDX_RESULT, 32'h0e);
		rchk("irq_stat", IDX_IRQ_STAT, 32'h03);
		end_of_test();
	end

	initial begin
		#3000000;
		error_cnt++;
		end_of_test();
	end
endmodule
